// file: dv/pfsc_monitor_model.sv
// Behavioural fault monitors that report a requested fault pattern after a set lag.
`timescale 1ns/1ps
module pfsc_monitor_model (
    // Clock
    input  wire logic       mclk_in,
    // Requested fault pattern and reporting lag in cycles
    input  wire logic [4:0] fault_req_in,
    input  wire logic [3:0] lag_in,
    // Monitor levels toward the block
    output logic      [4:0] fault_out
);
    logic [3:0] wait_q = 4'h0;

    initial fault_out = 5'h00;

    // A slow monitor filters a change before reporting it, so the block must not rely on speed.
    always @(posedge mclk_in) begin
        if (fault_req_in == fault_out) begin
            wait_q <= 4'h0;
        end else if (wait_q >= lag_in) begin
            fault_out <= fault_req_in;
            wait_q    <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// file: dv/pfsc_power_fault_shutdown_tb_top.sv
// Self-checking bench for the power fault shutdown control block.
`timescale 1ns/1ps
module pfsc_power_fault_shutdown_tb_top;
    logic        mclk_in      = 1'b0;
    logic        srst_in      = 1'b1;
    logic [7:0]  addr_in      = 8'h00;
    logic [31:0] wdata_in     = 32'h0000_0000;
    logic        wr_in        = 1'b0;
    logic        rd_in        = 1'b0;
    logic        boot_init_in = 1'b0;
    logic [31:0] rdata_out;
    logic [4:0]  fault_req    = 5'h00;
    logic [3:0]  lag          = 4'h0;
    logic [4:0]  fault_lvl;
    wire  [5:0]  outs;
    int          mismatches   = 0;
    int          check_count  = 0;
    integer      seed         = 32'h5a2a;
    int          ctrl_m;
    int          i;

    always #5 mclk_in = ~mclk_in;

    pfsc_monitor_model i_pfsc_monitor_model (
        .mclk_in(mclk_in), .fault_req_in(fault_req), .lag_in(lag), .fault_out(fault_lvl)
    );

    pfsc_power_fault_shutdown i_pfsc_power_fault_shutdown (
        .mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .boot_init_in(boot_init_in),
        .vsd_overvoltage_in(fault_lvl[0]), .overtemp_in(fault_lvl[1]),
        .clock_loss_in(fault_lvl[2]), .clock_watchdog_in(fault_lvl[3]),
        .vs_undervoltage_in(fault_lvl[4]), .sleep_req_out(outs[0]), .lin_off_out(outs[1]),
        .bridge_driver_off_out(outs[2]), .charge_pump_off_out(outs[3]),
        .attenuator_off_out(outs[4]), .watchdog_reset_req_out(outs[5])
    );

    function automatic logic [31:0] view(input int c);
        return (c & pfsc_pkg::CTRL_WRITE_MASK) | pfsc_pkg::CTRL_ONES_MASK;
    endfunction

    // Order of the result: watchdog reset, attenuator, pump, bridge, LIN, sleep.
    function automatic logic [5:0] expect_outs(input int c, input logic [4:0] f);
        logic ov;
        logic lin;
        logic core;
        ov   = f[0] & ~c[14];
        lin  = ov | (f[1] & ~c[7]) | (f[3] & ~c[1]) | (f[4] & ~c[8]);
        core = ov | (f[1] & ~c[24]) | (f[1] & ~c[7]) | (f[2] & ~c[25]) | (f[3] & ~c[1]);
        return {f[3] & ~c[26], ov, core, core, lin, ov | f[1]};
    endfunction

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        if (a == pfsc_pkg::CTRL_STS_OFFSET) ctrl_m = d;
    endtask

    task automatic bus_read(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, exp, what);
    endtask

    // Waits for the monitors to report, then for the synchroniser and output register.
    task automatic apply_faults(input logic [4:0] f, input logic [3:0] l);
        int n;
        n = 0;
        @(posedge mclk_in);
        fault_req <= f;
        lag       <= l;
        @(posedge mclk_in);
        while (fault_lvl !== f && n < 40) begin
            @(posedge mclk_in);
            n++;
        end
        if (n == 40) begin
            $display("Error at %0t: monitors never reported the fault pattern", $time);
            mismatches++;
            wrap_up();
        end
        repeat (4) @(posedge mclk_in);
        #1 check({26'h0, outs}, {26'h0, expect_outs(ctrl_m, f)}, "outputs");
    endtask

    initial begin
        repeat (16) @(posedge mclk_in);
        srst_in <= 1'b0;
        ctrl_m = pfsc_pkg::CTRL_RESET_VALUE;
        bus_read(8'h30, view(ctrl_m), "reset view");
        bus_read(8'h40, 32'h0000_0000, "unmapped read");
        @(posedge mclk_in);
        boot_init_in <= 1'b1;
        @(posedge mclk_in);
        boot_init_in <= 1'b0;
        ctrl_m = pfsc_pkg::CTRL_BOOT_VALUE;
        bus_read(8'h30, view(ctrl_m), "boot view");
        bus_write(8'h30, 32'hFFFF_FFFF);
        bus_read(8'h30, 32'h8700_4182, "ones view");
        bus_write(8'h34, 32'h0000_0000);
        bus_read(8'h30, 32'h8700_4182, "read-only write");
        @(posedge mclk_in);
        boot_init_in <= 1'b1;
        wr_in        <= 1'b1;
        addr_in      <= 8'h30;
        wdata_in     <= 32'h0000_4000;
        @(posedge mclk_in);
        boot_init_in <= 1'b0;
        wr_in        <= 1'b0;
        ctrl_m = 32'h0000_4000;
        bus_read(8'h30, 32'h8000_4000, "boot with write");
        bus_write(8'h30, 32'h0000_0000);
        bus_read(8'h30, 32'h8000_0000, "zeros view");
        $display("Test register access done");
        @(posedge mclk_in);
        fault_req <= 5'h01;
        repeat (3) @(posedge mclk_in);
        #1 check({31'h0, outs[0]}, 32'h0000_0000, "early sleep");
        @(posedge mclk_in);
        #1 check({26'h0, outs}, 32'h0000_001F, "overvoltage off");
        bus_read(8'h34, 32'h0000_1F01, "fault status");
        apply_faults(5'h00, 4'h0);
        $display("Test fault latency done");
        for (i = 0; i < 40; i++) begin
            bus_write(8'h30, $random(seed));
            apply_faults(5'($random(seed)), 4'($random(seed)));
        end
        $display("Test random faults done");
        apply_faults(5'h00, 4'h0);
        @(posedge mclk_in);
        srst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        srst_in <= 1'b0;
        ctrl_m = pfsc_pkg::CTRL_RESET_VALUE;
        bus_read(8'h30, view(ctrl_m), "second reset view");
        apply_faults(5'h1F, 4'h3);
        $display("Test second reset done");
        wrap_up();
    end
endmodule

// file: src/pfsc_fault_if.sv
// Interface carrying the synchronised fault levels between block modules.
`timescale 1ns/1ps
interface pfsc_fault_if;
    logic [pfsc_pkg::FAULT_W-1:0] fault;

    modport src (
        output fault
    );

    modport dst (
        input  fault
    );
endinterface

// file: src/pfsc_fault_sync.sv
// Two stage synchroniser for the asynchronous fault monitor levels.
`timescale 1ns/1ps
module pfsc_fault_sync (
    // Clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         srst_in,
    // Raw monitor levels
    input  wire logic [pfsc_pkg::FAULT_W-1:0] fault_raw_in,
    // Synchronised levels
    pfsc_fault_if.src                         sync_out
);

    typedef struct packed {
        logic [pfsc_pkg::FAULT_W-1:0] meta;
        logic [pfsc_pkg::FAULT_W-1:0] stable;
    } pfsc_sync_state_t;

    pfsc_sync_state_t st_q;
    pfsc_sync_state_t st_d;

    // The first stage feeds only the second stage, never any logic.
    always_comb begin
        st_d        = st_q;
        st_d.meta   = fault_raw_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out.fault = st_q.stable;

endmodule

// file: src/pfsc_pkg.sv
// Package of shared constants for the power fault shutdown control block.
package pfsc_pkg;

    // Register map, byte addresses on the word-wide register port.
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  CTRL_STS_OFFSET = 8'h30;
    localparam logic [7:0]  FAULT_STS_OFFSET = 8'h34;

    // Control word values.
    localparam logic [31:0] CTRL_RESET_VALUE = 32'h06E3_7EF3;
    localparam logic [31:0] CTRL_BOOT_VALUE  = 32'h82E3_7EF3;
    localparam logic [31:0] CTRL_WRITE_MASK  = 32'h0700_4182;
    localparam logic [31:0] CTRL_ONES_MASK   = 32'h8000_0000;

    // Control field positions, all disable bits are low active.
    localparam int unsigned POS_CLK_WDT_RESET_OFF  = 26;
    localparam int unsigned POS_CLK_LOSS_OFF       = 25;
    localparam int unsigned POS_OT_SWITCH_OFF      = 24;
    localparam int unsigned POS_VSD_OV_SLEEP_OFF   = 14;
    localparam int unsigned POS_LIN_UV_OFF         = 8;
    localparam int unsigned POS_OT_MODULE_OFF      = 7;
    localparam int unsigned POS_CLK_WDT_POWER_OFF  = 1;

    // Fault vector layout.
    localparam int unsigned FAULT_W       = 5;
    localparam int unsigned F_VSD_OV      = 0;
    localparam int unsigned F_OVERTEMP    = 1;
    localparam int unsigned F_CLK_LOSS    = 2;
    localparam int unsigned F_CLK_WDT     = 3;
    localparam int unsigned F_VS_UV       = 4;

    // Fault status word layout.
    localparam int unsigned STS_FAULT_LSB  = 0;
    localparam int unsigned STS_OUT_LSB    = 8;
    localparam int unsigned OUT_W          = 6;

    // Synchroniser depth for pin level inputs.
    localparam int unsigned SYNC_STAGES = 2;

endpackage

// file: src/pfsc_power_fault_shutdown.sv
// Fault driven shutdown control for the power modules, with its register.
// Behaviour
// [RL1] Driver supply overvoltage: sleep, all modules off.
// [RL2] Modules return once overvoltage clears.
// [RL3] Bit 14 low enables overvoltage shutdown.
// [RL4] Overtemperature always requests sleep mode.
// [RL5] Bit 24 low: pump, bridge off on overtemperature.
// [RL6] Bit 25 low: clock loss shuts power switches.
// [RL7] Bit 26 low: clock watchdog may reset.
// [RL8] Bit 8 low: undervoltage shuts LIN transmitter.
// [RL9] Bit 7 low: overtemperature stops LIN, bridge, pump.
// [RL10] Bit 1 low: clock watchdog switches power off.
// [RL11] Bit 31 reads one, other reserved zero.
// [RL12] Reset value, then boot load overwrites register.
// [RL13] Control register is word wide at 30h.
// [RL14] Gated faults drive registered, self clearing outputs.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module pfsc_power_fault_shutdown (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    // Boot loader strobe
    input  wire logic        boot_init_in,
    // Fault monitor levels, asynchronous
    input  wire logic        vsd_overvoltage_in,
    input  wire logic        overtemp_in,
    input  wire logic        clock_loss_in,
    input  wire logic        clock_watchdog_in,
    input  wire logic        vs_undervoltage_in,
    // Power module controls, high means switched off or requested
    output logic             sleep_req_out,
    output logic             lin_off_out,
    output logic             bridge_driver_off_out,
    output logic             charge_pump_off_out,
    output logic             attenuator_off_out,
    output logic             watchdog_reset_req_out
);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic        sleep;
        logic        lin_off;
        logic        bridge_driver_off;
        logic        cp_off;
        logic        atten_off;
        logic        wdt_rst;
    } pfsc_top_state_t;

    pfsc_top_state_t st_q;
    pfsc_top_state_t st_d;

    pfsc_fault_if    fault_bus ();

    pfsc_fault_sync u_sync (
        .mclk_in      (mclk_in),
        .srst_in      (srst_in),
        .fault_raw_in ({vs_undervoltage_in, clock_watchdog_in, clock_loss_in,
                        overtemp_in, vsd_overvoltage_in}),
        .sync_out     (fault_bus.src)
    );

    // A fault acts only while its low active disable bit is clear.
    function automatic logic gate_fault(input logic fault, input logic disable_bit);
        return fault & ~disable_bit;
    endfunction

    // Readback hides reserved bits even though the stored reset value sets some.
    function automatic logic [31:0] ctrl_view(input logic [31:0] ctrl);
        return (ctrl & pfsc_pkg::CTRL_WRITE_MASK) | pfsc_pkg::CTRL_ONES_MASK;
    endfunction

    logic [pfsc_pkg::FAULT_W-1:0] flt;
    logic                         ov_act;
    logic                         ot_sw_act;
    logic                         ot_mod_act;
    logic                         cl_act;
    logic                         wdt_pwr_act;
    logic                         wdt_rst_act;
    logic                         uv_act;
    logic [pfsc_pkg::OUT_W-1:0]   out_vec;

    assign flt = fault_bus.fault;
    assign out_vec = {st_q.wdt_rst, st_q.atten_off, st_q.cp_off, st_q.bridge_driver_off,
                      st_q.lin_off, st_q.sleep};

    always_comb begin
        ov_act      = gate_fault(flt[pfsc_pkg::F_VSD_OV],
                                 st_q.ctrl[pfsc_pkg::POS_VSD_OV_SLEEP_OFF]);        // RL3
        ot_sw_act   = gate_fault(flt[pfsc_pkg::F_OVERTEMP],
                                 st_q.ctrl[pfsc_pkg::POS_OT_SWITCH_OFF]);           // RL5
        ot_mod_act  = gate_fault(flt[pfsc_pkg::F_OVERTEMP],
                                 st_q.ctrl[pfsc_pkg::POS_OT_MODULE_OFF]);           // RL9
        cl_act      = gate_fault(flt[pfsc_pkg::F_CLK_LOSS],
                                 st_q.ctrl[pfsc_pkg::POS_CLK_LOSS_OFF]);            // RL6
        wdt_pwr_act = gate_fault(flt[pfsc_pkg::F_CLK_WDT],
                                 st_q.ctrl[pfsc_pkg::POS_CLK_WDT_POWER_OFF]);       // RL10
        wdt_rst_act = gate_fault(flt[pfsc_pkg::F_CLK_WDT],
                                 st_q.ctrl[pfsc_pkg::POS_CLK_WDT_RESET_OFF]);       // RL7
        uv_act      = gate_fault(flt[pfsc_pkg::F_VS_UV],
                                 st_q.ctrl[pfsc_pkg::POS_LIN_UV_OFF]);              // RL8
    end

    always_comb begin
        st_d = st_q;
        // Outputs follow the gated faults every cycle, so they clear on their own.
        st_d.sleep     = ov_act | flt[pfsc_pkg::F_OVERTEMP];                        // RL1 RL4
        st_d.lin_off   = ov_act | ot_mod_act | wdt_pwr_act | uv_act;                // RL1 RL8
        st_d.bridge_driver_off  = ov_act | ot_sw_act | ot_mod_act | cl_act | wdt_pwr_act;    // RL14
        st_d.cp_off    = ov_act | ot_sw_act | ot_mod_act | cl_act | wdt_pwr_act;    // RL14
        st_d.atten_off = ov_act;                                                    // RL2
        st_d.wdt_rst   = wdt_rst_act;                                               // RL7
        // Boot load comes first so a software write in the same cycle still lands.
        if (boot_init_in) begin
            st_d.ctrl = pfsc_pkg::CTRL_BOOT_VALUE;                                  // RL12
        end
        if (wr_in && addr_in == pfsc_pkg::CTRL_STS_OFFSET) begin
            st_d.ctrl = (wdata_in & pfsc_pkg::CTRL_WRITE_MASK)
                      | (st_d.ctrl & ~pfsc_pkg::CTRL_WRITE_MASK);                   // RL13
        end
        // Read data stand for exactly one cycle, zero otherwise.
        st_d.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                pfsc_pkg::CTRL_STS_OFFSET: begin
                    st_d.rdata = ctrl_view(st_q.ctrl);                              // RL11
                end
                pfsc_pkg::FAULT_STS_OFFSET: begin
                    st_d.rdata[pfsc_pkg::STS_FAULT_LSB +: pfsc_pkg::FAULT_W] = flt;
                    st_d.rdata[pfsc_pkg::STS_OUT_LSB +: pfsc_pkg::OUT_W]     = out_vec;
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st_q      <= '0;
            st_q.ctrl <= pfsc_pkg::CTRL_RESET_VALUE;                                // RL12
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_out              = st_q.rdata;
    assign sleep_req_out          = st_q.sleep;
    assign lin_off_out            = st_q.lin_off;
    assign bridge_driver_off_out  = st_q.bridge_driver_off;
    assign charge_pump_off_out    = st_q.cp_off;
    assign attenuator_off_out     = st_q.atten_off;
    assign watchdog_reset_req_out = st_q.wdt_rst;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    a_ov_full_shutdown: assert property ( // RL1
        flt[pfsc_pkg::F_VSD_OV] && !st_q.ctrl[pfsc_pkg::POS_VSD_OV_SLEEP_OFF]
        |=> sleep_req_out && lin_off_out && bridge_driver_off_out
            && charge_pump_off_out && attenuator_off_out)
        else $error("overvoltage did not shut all modules down");

    a_all_faults_gone: assert property ( // RL2
        (flt == '0) [*2] |-> !lin_off_out && !bridge_driver_off_out
            && !charge_pump_off_out && !attenuator_off_out && !sleep_req_out)
        else $error("modules stayed off after faults cleared");

    a_ov_disable_bit: assert property ( // RL3
        st_q.ctrl[pfsc_pkg::POS_VSD_OV_SLEEP_OFF] |=> !attenuator_off_out)
        else $error("attenuators off while overvoltage shutdown disabled");

    a_ot_sleep_entry: assert property ( // RL4
        flt[pfsc_pkg::F_OVERTEMP] |=> sleep_req_out)
        else $error("overtemperature did not request sleep");

    a_ot_pump_bridge: assert property ( // RL5
        flt[pfsc_pkg::F_OVERTEMP] && !st_q.ctrl[pfsc_pkg::POS_OT_SWITCH_OFF]
        |=> charge_pump_off_out && bridge_driver_off_out)
        else $error("overtemperature left pump or bridge on");

    a_clock_loss_off: assert property ( // RL6
        flt[pfsc_pkg::F_CLK_LOSS] && !st_q.ctrl[pfsc_pkg::POS_CLK_LOSS_OFF]
        |=> charge_pump_off_out && bridge_driver_off_out)
        else $error("clock loss did not switch power off");

    a_wdt_reset_gate: assert property ( // RL7
        watchdog_reset_req_out == $past(flt[pfsc_pkg::F_CLK_WDT]
            && !st_q.ctrl[pfsc_pkg::POS_CLK_WDT_RESET_OFF]))
        else $error("watchdog reset request does not match its gate");

    a_uv_lin_off: assert property ( // RL8
        flt[pfsc_pkg::F_VS_UV] && !st_q.ctrl[pfsc_pkg::POS_LIN_UV_OFF]
        |=> lin_off_out)
        else $error("undervoltage left LIN transmitter on");

    a_ot_module_off: assert property ( // RL9
        flt[pfsc_pkg::F_OVERTEMP] && !st_q.ctrl[pfsc_pkg::POS_OT_MODULE_OFF]
        |=> lin_off_out && bridge_driver_off_out && charge_pump_off_out)
        else $error("overtemperature left LIN, bridge or pump on");

    a_wdt_power_off: assert property ( // RL10
        flt[pfsc_pkg::F_CLK_WDT] && !st_q.ctrl[pfsc_pkg::POS_CLK_WDT_POWER_OFF]
        |=> lin_off_out && bridge_driver_off_out && charge_pump_off_out)
        else $error("clock watchdog left power devices on");

    a_reserved_read: assert property ( // RL11
        rd_in && addr_in == pfsc_pkg::CTRL_STS_OFFSET
        |=> rdata_out[31] && rdata_out[30:27] == 4'h0 && rdata_out[23:15] == 9'h000
            && rdata_out[13:9] == 5'h00 && rdata_out[6:2] == 5'h00 && !rdata_out[0])
        else $error("reserved control bits read wrong");

    a_reset_value: assert property ( // RL12
        disable iff (1'b0)
        srst_in |=> st_q.ctrl == pfsc_pkg::CTRL_RESET_VALUE)
        else $error("control word not at reset value after reset");

    a_boot_load: assert property ( // RL12
        boot_init_in && !wr_in |=> st_q.ctrl == pfsc_pkg::CTRL_BOOT_VALUE)
        else $error("boot load did not set control word");

    a_word_write: assert property ( // RL13
        wr_in && addr_in == pfsc_pkg::CTRL_STS_OFFSET
        |=> (st_q.ctrl & pfsc_pkg::CTRL_WRITE_MASK)
            == ($past(wdata_in) & pfsc_pkg::CTRL_WRITE_MASK))
        else $error("word write did not reach control bits");

    a_read_one_cycle: assert property ( // RL14
        !rd_in |=> rdata_out == 32'h0000_0000)
        else $error("read data stood without a read");

    a_ov_disabled_sleep: assert property ( // RL3
        st_q.ctrl[pfsc_pkg::POS_VSD_OV_SLEEP_OFF] && !flt[pfsc_pkg::F_OVERTEMP]
        |=> !sleep_req_out)
        else $error("sleep requested while overvoltage shutdown disabled");

    a_sleep_needs_fault: assert property ( // RL4
        !flt[pfsc_pkg::F_VSD_OV] && !flt[pfsc_pkg::F_OVERTEMP]
        |=> !sleep_req_out)
        else $error("sleep requested with no overvoltage or overtemperature");

    a_atten_needs_ov: assert property ( // RL2
        !flt[pfsc_pkg::F_VSD_OV] |=> !attenuator_off_out)
        else $error("attenuators off with no overvoltage");

    a_ot_switch_kept: assert property ( // RL5
        st_q.ctrl[pfsc_pkg::POS_OT_SWITCH_OFF] && st_q.ctrl[pfsc_pkg::POS_OT_MODULE_OFF]
        && !flt[pfsc_pkg::F_VSD_OV] && !flt[pfsc_pkg::F_CLK_LOSS]
        && !flt[pfsc_pkg::F_CLK_WDT]
        |=> !charge_pump_off_out)
        else $error("pump off with overtemperature shutdown disabled");

    a_clock_loss_kept: assert property ( // RL6
        st_q.ctrl[pfsc_pkg::POS_CLK_LOSS_OFF] && !flt[pfsc_pkg::F_VSD_OV]
        && !flt[pfsc_pkg::F_OVERTEMP] && !flt[pfsc_pkg::F_CLK_WDT]
        |=> !bridge_driver_off_out)
        else $error("bridge off with clock loss shutdown disabled");

    a_clock_loss_lin: assert property ( // RL6
        !flt[pfsc_pkg::F_VSD_OV] && !flt[pfsc_pkg::F_OVERTEMP]
        && !flt[pfsc_pkg::F_CLK_WDT] && !flt[pfsc_pkg::F_VS_UV]
        |=> !lin_off_out)
        else $error("LIN off from clock loss alone");

    a_wdt_reset_set: assert property ( // RL7
        flt[pfsc_pkg::F_CLK_WDT] && !st_q.ctrl[pfsc_pkg::POS_CLK_WDT_RESET_OFF]
        |=> watchdog_reset_req_out)
        else $error("clock watchdog reset not requested");

    a_wdt_reset_quiet: assert property ( // RL7
        st_q.ctrl[pfsc_pkg::POS_CLK_WDT_RESET_OFF] |=> !watchdog_reset_req_out)
        else $error("watchdog reset requested while blocked");

    a_uv_lin_kept: assert property ( // RL8
        st_q.ctrl[pfsc_pkg::POS_LIN_UV_OFF] && !flt[pfsc_pkg::F_VSD_OV]
        && !flt[pfsc_pkg::F_OVERTEMP] && !flt[pfsc_pkg::F_CLK_WDT]
        |=> !lin_off_out)
        else $error("LIN off with undervoltage shutdown disabled");

    a_uv_lin_only: assert property ( // RL8
        !flt[pfsc_pkg::F_VSD_OV] && !flt[pfsc_pkg::F_OVERTEMP]
        && !flt[pfsc_pkg::F_CLK_LOSS] && !flt[pfsc_pkg::F_CLK_WDT]
        |=> !bridge_driver_off_out && !charge_pump_off_out)
        else $error("undervoltage reached bridge or pump");

    a_ot_lin_kept: assert property ( // RL9
        st_q.ctrl[pfsc_pkg::POS_OT_MODULE_OFF] && !flt[pfsc_pkg::F_VSD_OV]
        && !flt[pfsc_pkg::F_CLK_WDT] && !flt[pfsc_pkg::F_VS_UV]
        |=> !lin_off_out)
        else $error("LIN off with overtemperature switch-off disabled");

    a_wdt_power_kept: assert property ( // RL10
        st_q.ctrl[pfsc_pkg::POS_CLK_WDT_POWER_OFF] && !flt[pfsc_pkg::F_VSD_OV]
        && !flt[pfsc_pkg::F_OVERTEMP] && !flt[pfsc_pkg::F_VS_UV]
        |=> !lin_off_out)
        else $error("LIN off with clock watchdog shutdown disabled");

    a_read_fields: assert property ( // RL11
        rd_in && addr_in == pfsc_pkg::CTRL_STS_OFFSET
        |=> rdata_out[pfsc_pkg::POS_VSD_OV_SLEEP_OFF]
                == $past(st_q.ctrl[pfsc_pkg::POS_VSD_OV_SLEEP_OFF])
            && rdata_out[pfsc_pkg::POS_LIN_UV_OFF]
                == $past(st_q.ctrl[pfsc_pkg::POS_LIN_UV_OFF]))
        else $error("control field read back wrong");

    a_boot_write_both: assert property ( // RL12
        boot_init_in && wr_in && addr_in == pfsc_pkg::CTRL_STS_OFFSET
        |=> (st_q.ctrl & ~pfsc_pkg::CTRL_WRITE_MASK)
            == (pfsc_pkg::CTRL_BOOT_VALUE & ~pfsc_pkg::CTRL_WRITE_MASK))
        else $error("boot load lost beside a same cycle write");

    a_reset_outputs: assert property ( // RL12
        disable iff (1'b0)
        srst_in |=> !sleep_req_out && !lin_off_out && !bridge_driver_off_out
            && !charge_pump_off_out && !attenuator_off_out && !watchdog_reset_req_out
            && rdata_out == 32'h0000_0000)
        else $error("outputs not cleared by reset");

    a_unmapped_read: assert property ( // RL13
        rd_in && addr_in != pfsc_pkg::CTRL_STS_OFFSET
        && addr_in != pfsc_pkg::FAULT_STS_OFFSET
        |=> rdata_out == 32'h0000_0000)
        else $error("unmapped read returned data");

    a_ctrl_holds: assert property ( // RL13
        !boot_init_in && !(wr_in && addr_in == pfsc_pkg::CTRL_STS_OFFSET)
        |=> $stable(st_q.ctrl))
        else $error("control word changed with no write or boot load");

    a_status_faults: assert property ( // RL14
        rd_in && addr_in == pfsc_pkg::FAULT_STS_OFFSET
        |=> rdata_out[pfsc_pkg::STS_FAULT_LSB +: pfsc_pkg::FAULT_W] == $past(flt))
        else $error("status read shows wrong fault levels");

    a_status_outputs: assert property ( // RL14
        rd_in && addr_in == pfsc_pkg::FAULT_STS_OFFSET
        |=> rdata_out[pfsc_pkg::STS_OUT_LSB +: pfsc_pkg::OUT_W]
            == $past({watchdog_reset_req_out, attenuator_off_out, charge_pump_off_out,
                      bridge_driver_off_out, lin_off_out, sleep_req_out}))
        else $error("status read shows wrong output levels");

    a_quiet_no_fault: assert property ( // RL14
        flt == '0 |=> !lin_off_out && !bridge_driver_off_out && !watchdog_reset_req_out)
        else $error("output off one cycle after all faults cleared");

endmodule
